// ---- dv/efh_host_model.sv ----
// Behavioural host engine: line events, fan counts and buffer pointer steps
`timescale 1ns/1ps
`default_nettype none

module efh_host_model (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire efh_pkg::efh_host_evt_t req_i,
   input  wire logic [1:0][15:0]       cnt_i,
   input  wire logic                   adv_i,
   output efh_pkg::efh_host_evt_t      evt_o,
   output logic [1:0][15:0]            tach_o,
   output logic                        rd_adv_o,
   output logic                        wr_adv_o
);
   // ============================================================
   // Outputs
   // Registered, so every change lands just after an edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         evt_o    <= '0;
         tach_o   <= '0;
         rd_adv_o <= 1'b0;
         wr_adv_o <= 1'b0;
      end else begin
         evt_o    <= req_i;
         tach_o   <= cnt_i;
         rd_adv_o <= adv_i;
         wr_adv_o <= adv_i;
      end
   end
endmodule : efh_host_model

`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the fan and temperature host register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                        sys_clk_i = 1'b0;
   logic                        rst_i = 1'b1;
   logic [7:0]                  addr_i = 8'h00;
   logic [7:0]                  wdata_i = 8'h00;
   logic                        wr_i = 1'b0;
   logic                        rd_i = 1'b0;
   logic                        adv = 1'b0;
   logic [7:0]                  rdata_o;
   logic [1:0][15:0]            cnt = '0;
   logic [1:0][15:0]            tach;
   logic [1:0][15:0]            lim;
   efh_pkg::efh_host_evt_t      req = '0;
   efh_pkg::efh_host_evt_t      evt;
   logic                        rd_adv;
   logic                        wr_adv;
   efh_pkg::efh_fan_cfg_t [2:0] fan;
   efh_pkg::efh_host_cfg_t      hcfg;
   int                          miscompares = 0;
   int                          checks = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   efh_host_model i_model (.clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .cnt_i(cnt),
      .adv_i(adv), .evt_o(evt), .tach_o(tach), .rd_adv_o(rd_adv), .wr_adv_o(wr_adv));

   efh_regs i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tach_count_i(tach), .host_evt_i(evt),
      .rd_adv_i(rd_adv), .wr_adv_i(wr_adv), .fan_cfg_o(fan), .tach_limit_o(lim),
      .host_cfg_o(hcfg));

   // ============================================================
   // Bus and compare tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i    <= 1'b0;
      #1;
   endtask : wr

   // Read data stand one cycle only, so sample right after the answer edge
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      rd_i   <= 1'b0;
      #1 chk({8'h00, rdata_o}, {8'h00, e});
   endtask : rdc

   // Events are pulses: a held level would set the flag again each cycle
   task automatic pulse(input logic [7:0] v, input bit hold);
      @(posedge sys_clk_i);
      req <= v;
      if (!hold) begin
         @(posedge sys_clk_i);
         req <= '0;
      end
      repeat (3) @(posedge sys_clk_i);
   endtask : pulse

   // ============================================================
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         rdc(efh_pkg::FAN_START_ADDR[i], 8'h00);
         rdc(efh_pkg::FAN_CTRL_ADDR[i], 8'h00);
         rdc(efh_pkg::FAN_INTV_ADDR[i], 8'h7F);
         chk(16'(fan[i].temp_interval), 16'h001F);
      end
      rdc(efh_pkg::HOST_TADDR_ADDR, 8'h00);
      rdc(efh_pkg::HOST_WLEN_ADDR, 8'h00);
      rdc(efh_pkg::HOST_RLEN_ADDR, 8'h00);
      rdc(efh_pkg::HOST_STATUS_ADDR, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_fan;
      logic [5:0] lo;
      for (int k = 1; k >= 0; k--) begin
         for (int i = 0; i < 3; i++) begin
            lo = 6'(8'h28 + i);
            wr(efh_pkg::FAN_START_ADDR[i], {k[0], 7'(8'h41 + i)});
            wr(efh_pkg::FAN_CTRL_ADDR[i], {k[0], 1'b0, lo});
            wr(efh_pkg::FAN_INTV_ADDR[i], {k[0], 2'b00, 5'(8'h10 + i)});
            chk(16'(fan[i].start_duty), 16'(8'h41 + i));
            chk(16'(fan[i].slope), 16'({k[0], lo}));
            chk(16'(fan[i].smooth_en), 16'(k));
            chk(16'(fan[i].direct_down), 16'(k));
            chk(16'(fan[i].temp_interval), 16'(8'h10 + i));
            rdc(efh_pkg::FAN_START_ADDR[i], {k[0], 7'(8'h41 + i)});
         end
      end
      $display("test fan done");
   endtask : t_fan

   task automatic t_tach;
      @(posedge sys_clk_i);
      cnt <= {16'hABCD, 16'h1234};
      repeat (2) @(posedge sys_clk_i);
      rdc(8'h80, 8'h34);
      @(posedge sys_clk_i);
      cnt[0] <= 16'h5678;
      repeat (2) @(posedge sys_clk_i);
      rdc(8'h81, 8'h12);
      rdc(8'h82, 8'hCD);
      rdc(8'h83, 8'hAB);
      wr(8'h80, 8'hFF);
      rdc(8'h80, 8'h78);
      wr(8'h84, 8'h11);
      wr(8'h85, 8'h22);
      wr(8'h86, 8'h33);
      wr(8'h87, 8'h44);
      chk(lim[0], 16'h2211);
      chk(lim[1], 16'h4433);
      rdc(8'h86, 8'h33);
      rdc(8'h90, 8'h00);
      $display("test tach done");
   endtask : t_tach

   task automatic t_host;
      // Command fields change on any write; here they are written while the host is idle
      wr(efh_pkg::HOST_TADDR_ADDR, 8'hA5);
      wr(efh_pkg::HOST_WLEN_ADDR, 8'h5A);
      wr(efh_pkg::HOST_RLEN_ADDR, 8'h3C);
      chk(16'(hcfg.target_addr), 16'h00A5);
      chk(16'(hcfg.write_length_field), 16'h005A);
      chk(16'(hcfg.read_length_field), 16'h003C);
      rdc(efh_pkg::HOST_TADDR_ADDR, 8'hA5);
      rdc(efh_pkg::HOST_WLEN_ADDR, 8'h5A);
      rdc(efh_pkg::HOST_RLEN_ADDR, 8'h3C);
      $display("test host done");
   endtask : t_host

   task automatic t_status;
      int bits [5] = '{6, 5, 3, 2, 1};
      foreach (bits[j]) begin
         pulse(8'(1 << (bits[j] + 1)), 1'b0);
         rdc(8'h88, 8'(1 << bits[j]));
         wr(8'h88, 8'h00);
         rdc(8'h88, 8'(1 << bits[j]));
         wr(8'h88, 8'(1 << bits[j]));
         rdc(8'h88, 8'h00);
      end
      pulse(8'h11, 1'b0);
      rdc(8'h88, 8'h00);
      pulse(8'h09, 1'b0);
      rdc(8'h88, 8'h04);
      wr(8'h88, 8'h04);
      // Stop event and its clear meet in one cycle: the set must win
      @(posedge sys_clk_i);
      req     <= 8'h04;
      addr_i  <= 8'h88;
      wdata_i <= 8'h02;
      @(posedge sys_clk_i);
      req     <= '0;
      wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      wr_i    <= 1'b0;
      rdc(8'h88, 8'h02);
      wr(8'h88, 8'h02);
      rdc(8'h88, 8'h00);
      pulse(8'h22, 1'b1);
      rdc(8'h88, 8'h11);
      wr(8'h88, 8'h11);
      rdc(8'h88, 8'h11);
      pulse(8'h00, 1'b1);
      rdc(8'h88, 8'h00);
      $display("test status done");
   endtask : t_status

   task automatic t_ptr;
      @(posedge sys_clk_i);
      adv <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      adv <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1 chk(16'(hcfg.rd_ptr), 16'h0003);
      chk(16'(hcfg.wr_ptr), 16'h0004);
      wr(8'h88, 8'h80);
      @(posedge sys_clk_i);
      #1 chk(16'(hcfg.rd_ptr), 16'h0000);
      chk(16'(hcfg.wr_ptr), 16'h0001);
      rdc(8'h88, 8'h00);
      $display("test pointer done");
   endtask : t_ptr

   // ============================================================
   // Verdict and run control
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // Cuts a hang short; the whole run needs far fewer cycles
   initial begin
      repeat (50000) @(posedge sys_clk_i);
      miscompares++;
      give_verdict();
   end

   initial begin
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_fan();
      t_tach();
      t_host();
      t_status();
      t_ptr();
      give_verdict();
   end
endmodule : testbench

`default_nettype wire

// ---- pkg/efh_pkg.sv ----
// Register map, field layout and carrier types of the fan/temperature host bank
package efh_pkg;

   // ============================================================
   // Register indices
   localparam logic [2:0][7:0] FAN_START_ADDR = {8'h73, 8'h6B, 8'h63};
   localparam logic [2:0][7:0] FAN_CTRL_ADDR  = {8'h74, 8'h6C, 8'h64};
   localparam logic [2:0][7:0] FAN_INTV_ADDR  = {8'h75, 8'h6D, 8'h65};
   localparam logic [1:0][7:0] TACH_CNT_LO    = {8'h82, 8'h80};
   localparam logic [1:0][7:0] TACH_CNT_HI    = {8'h83, 8'h81};
   localparam logic [1:0][7:0] TACH_LIM_LO    = {8'h86, 8'h84};
   localparam logic [1:0][7:0] TACH_LIM_HI    = {8'h87, 8'h85};
   localparam logic [7:0] HOST_STATUS_ADDR = 8'h88;
   localparam logic [7:0] HOST_TADDR_ADDR  = 8'h89;
   localparam logic [7:0] HOST_WLEN_ADDR   = 8'h8A;
   localparam logic [7:0] HOST_RLEN_ADDR   = 8'h8B;

   // ============================================================
   // Reset values
   localparam logic [7:0]  FAN_START_RST = 8'h00;
   localparam logic [7:0]  FAN_CTRL_RST  = 8'h00;
   localparam logic [7:0]  FAN_INTV_RST  = 8'h7F;
   localparam logic [15:0] TACH_LIM_RST  = 16'h0000;
   localparam logic [7:0]  HOST_FLD_RST  = 8'h00;
   localparam logic [7:0]  RDATA_IDLE    = 8'h00;

   // ============================================================
   // Field positions
   localparam int START_SLOPE_MSB = 7;
   localparam int CTRL_SMOOTH     = 7;
   localparam int INTV_DIRECT     = 7;
   localparam int ST_PTR_CLR      = 7;
   localparam int ST_LINE_ERR     = 6;
   localparam int ST_TBIT_ERR     = 5;
   localparam int ST_HIZ          = 4;
   localparam int ST_WR_FCS       = 3;
   localparam int ST_RD_CHK       = 2;
   localparam int ST_DONE         = 1;
   localparam int ST_BUSY         = 0;

   // Buffer pointers after a clear: read byte 1, write byte 2
   localparam logic [3:0] RD_PTR_RST = 4'h0;
   localparam logic [2:0] WR_PTR_RST = 3'h1;

   // ============================================================
   // Carriers
   typedef struct packed {
      logic [6:0] start_duty;
      logic [6:0] slope;
      logic       smooth_en;
      logic       direct_down;
      logic [4:0] temp_interval;
   } efh_fan_cfg_t;

   typedef struct packed {
      logic line_fault;
      logic tbit_overrun;
      logic line_hiz;
      logic write_check_error;
      logic read_check_error_or_invalid;
      logic stop_seen;
      logic busy;
      logic alternate_sideband_mode;
   } efh_host_evt_t;

   typedef struct packed {
      logic [7:0] target_addr;
      logic [7:0] write_length_field;
      logic [7:0] read_length_field;
      logic [3:0] rd_ptr;
      logic [2:0] wr_ptr;
   } efh_host_cfg_t;

endpackage : efh_pkg

// ---- rtl/efh_regs.sv ----
// Register bank for automatic fan settings, fan 4/5 tachometers and temperature host
//
// Behaviour
// - Start-duty register: bits 6-0 start duty, bit 7 is slope bit 6.
// - Slope is 7 bits fixed point: bits 6-3 integer, bits 2-0 eighths.
// - Control bit 7 enables smoothing; bits 5-0 are low slope bits.
// - Interval bit 7 picks direct or slow decrease; bits 4-0 the interval.
// - Fans 4 and 5 show read-only 16-bit revolution counts as two bytes.
// - Fans 4 and 5 have read-write 16-bit limits as two bytes.
// - Writing 1 to status bit 7 clears both pointers; bit reads 0.
// - After pointer clear, read points at byte 1, write at byte 2.
// - Status bit 6 sets on line abnormal or contention; write clears.
// - Status bit 5 sets on responder timing bit overrun; write clears.
// - Status bit 4 shows whether the line is high impedance.
// - Status bit 3 flags write check error outside sideband mode; 1 clears.
// - Status bit 2 is read check error, or invalid flag in sideband.
// - Status bit 1 sets on stop condition; writing 1 clears it.
// - Status bit 0 reads 1 while a host command runs.
// - Target address register is sent as each transaction's address.
// - Write length register is sent as the write length field.
// - Read length register is sent as the read length field.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module efh_regs (
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_i,
   input  wire logic [7:0]             addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic [7:0]                  rdata_o,
   input  wire logic [1:0][15:0]       tach_count_i,
   input  wire efh_pkg::efh_host_evt_t host_evt_i,
   input  wire logic                   rd_adv_i,
   input  wire logic                   wr_adv_i,
   output efh_pkg::efh_fan_cfg_t [2:0] fan_cfg_o,
   output logic [1:0][15:0]            tach_limit_o,
   output efh_pkg::efh_host_cfg_t      host_cfg_o
);

   // ============================================================
   // State
   typedef struct packed {
      logic [2:0][7:0]  start;
      logic [2:0][7:0]  ctrl;
      logic [2:0][7:0]  intv;
      logic [1:0][15:0] lim;
      logic [1:0][7:0]  cnt_hi;
      logic [7:0]       taddr;
      logic [7:0]       wlen;
      logic [7:0]       rlen;
      logic             line_err;
      logic             tbit_err;
      logic             hiz;
      logic             wfcs;
      logic             rchk;
      logic             done;
      logic             busy;
      logic [3:0]       rd_ptr;
      logic [2:0]       wr_ptr;
      logic [7:0]       rdata;
   } efh_state_t;

   efh_state_t s_q;
   efh_state_t s_d;

   // Slope joins one bit of the start register with six of the control register
   function automatic logic [6:0] slope_of(input logic [7:0] start, input logic [7:0] ctrl);
      slope_of = {start[efh_pkg::START_SLOPE_MSB], ctrl[5:0]};
   endfunction : slope_of

   // Sticky flag: a set in the clearing cycle wins
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction : sticky

   logic       st_wr;
   logic [7:0] st_clr;
   assign st_wr  = wr_i && (addr_i == efh_pkg::HOST_STATUS_ADDR);
   assign st_clr = st_wr ? wdata_i : 8'h00;

   // ============================================================
   // Next state
   always_comb begin
      s_d       = s_q;
      s_d.rdata = efh_pkg::RDATA_IDLE;
      for (int c = 0; c < 3; c++) begin
         if (wr_i && addr_i == efh_pkg::FAN_START_ADDR[c]) begin
            s_d.start[c] = wdata_i;
         end
         if (wr_i && addr_i == efh_pkg::FAN_CTRL_ADDR[c]) begin
            s_d.ctrl[c] = wdata_i;
         end
         if (wr_i && addr_i == efh_pkg::FAN_INTV_ADDR[c]) begin
            s_d.intv[c] = wdata_i;
         end
      end
      for (int t = 0; t < 2; t++) begin
         if (wr_i && addr_i == efh_pkg::TACH_LIM_LO[t]) begin
            s_d.lim[t][7:0] = wdata_i;
         end
         if (wr_i && addr_i == efh_pkg::TACH_LIM_HI[t]) begin
            s_d.lim[t][15:8] = wdata_i;
         end
         // Freezing the high byte avoids a torn count if the counter carries
         if (rd_i && addr_i == efh_pkg::TACH_CNT_LO[t]) begin
            s_d.cnt_hi[t] = tach_count_i[t][15:8];
         end
      end
      if (wr_i && addr_i == efh_pkg::HOST_TADDR_ADDR) begin
         s_d.taddr = wdata_i;
      end
      if (wr_i && addr_i == efh_pkg::HOST_WLEN_ADDR) begin
         s_d.wlen = wdata_i;
      end
      if (wr_i && addr_i == efh_pkg::HOST_RLEN_ADDR) begin
         s_d.rlen = wdata_i;
      end

      // Status flags
      s_d.line_err = sticky(s_q.line_err, host_evt_i.line_fault,
                            st_clr[efh_pkg::ST_LINE_ERR]);
      s_d.tbit_err = sticky(s_q.tbit_err, host_evt_i.tbit_overrun,
                            st_clr[efh_pkg::ST_TBIT_ERR]);
      s_d.hiz      = host_evt_i.line_hiz;
      s_d.wfcs     = sticky(s_q.wfcs,
                            host_evt_i.write_check_error & ~host_evt_i.alternate_sideband_mode,
                            st_clr[efh_pkg::ST_WR_FCS]);
      s_d.rchk     = sticky(s_q.rchk, host_evt_i.read_check_error_or_invalid,
                            st_clr[efh_pkg::ST_RD_CHK]);
      s_d.done     = sticky(s_q.done, host_evt_i.stop_seen,
                            st_clr[efh_pkg::ST_DONE]);
      s_d.busy     = host_evt_i.busy;

      // Buffer pointers; the clear beats a same-cycle advance
      if (st_clr[efh_pkg::ST_PTR_CLR]) begin
         s_d.rd_ptr = efh_pkg::RD_PTR_RST;
         s_d.wr_ptr = efh_pkg::WR_PTR_RST;
      end else begin
         if (rd_adv_i) begin
            s_d.rd_ptr = s_q.rd_ptr + 4'h1;
         end
         if (wr_adv_i) begin
            s_d.wr_ptr = (s_q.wr_ptr == 3'h7) ? efh_pkg::WR_PTR_RST : s_q.wr_ptr + 3'h1;
         end
      end

      // Read port; unmapped indices answer zero
      if (rd_i) begin
         for (int c = 0; c < 3; c++) begin
            if (addr_i == efh_pkg::FAN_START_ADDR[c]) begin
               s_d.rdata = s_q.start[c];
            end
            if (addr_i == efh_pkg::FAN_CTRL_ADDR[c]) begin
               s_d.rdata = s_q.ctrl[c];
            end
            if (addr_i == efh_pkg::FAN_INTV_ADDR[c]) begin
               s_d.rdata = s_q.intv[c];
            end
         end
         for (int t = 0; t < 2; t++) begin
            if (addr_i == efh_pkg::TACH_CNT_LO[t]) begin
               s_d.rdata = tach_count_i[t][7:0];
            end
            if (addr_i == efh_pkg::TACH_CNT_HI[t]) begin
               s_d.rdata = s_q.cnt_hi[t];
            end
            if (addr_i == efh_pkg::TACH_LIM_LO[t]) begin
               s_d.rdata = s_q.lim[t][7:0];
            end
            if (addr_i == efh_pkg::TACH_LIM_HI[t]) begin
               s_d.rdata = s_q.lim[t][15:8];
            end
         end
         unique case (addr_i)
            efh_pkg::HOST_STATUS_ADDR: begin
               s_d.rdata = {1'b0, s_q.line_err, s_q.tbit_err, s_q.hiz,
                            s_q.wfcs, s_q.rchk, s_q.done, s_q.busy};
            end
            efh_pkg::HOST_TADDR_ADDR: begin
               s_d.rdata = s_q.taddr;
            end
            efh_pkg::HOST_WLEN_ADDR: begin
               s_d.rdata = s_q.wlen;
            end
            efh_pkg::HOST_RLEN_ADDR: begin
               s_d.rdata = s_q.rlen;
            end
            default: begin
            end
         endcase
      end
   end

   // ============================================================
   // Registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q          <= '0;
         s_q.start    <= {3{efh_pkg::FAN_START_RST}};
         s_q.ctrl     <= {3{efh_pkg::FAN_CTRL_RST}};
         s_q.intv     <= {3{efh_pkg::FAN_INTV_RST}};
         s_q.lim      <= {2{efh_pkg::TACH_LIM_RST}};
         s_q.taddr    <= efh_pkg::HOST_FLD_RST;
         s_q.wlen     <= efh_pkg::HOST_FLD_RST;
         s_q.rlen     <= efh_pkg::HOST_FLD_RST;
         s_q.rd_ptr   <= efh_pkg::RD_PTR_RST;
         s_q.wr_ptr   <= efh_pkg::WR_PTR_RST;
         s_q.rdata    <= efh_pkg::RDATA_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // ============================================================
   // Outputs
   assign rdata_o = s_q.rdata;

   always_comb begin
      for (int c = 0; c < 3; c++) begin
         fan_cfg_o[c].start_duty    = s_q.start[c][6:0];
         fan_cfg_o[c].slope         = slope_of(s_q.start[c], s_q.ctrl[c]);
         fan_cfg_o[c].smooth_en     = s_q.ctrl[c][efh_pkg::CTRL_SMOOTH];
         fan_cfg_o[c].direct_down   = s_q.intv[c][efh_pkg::INTV_DIRECT];
         fan_cfg_o[c].temp_interval = s_q.intv[c][4:0];
      end
   end

   assign tach_limit_o                   = s_q.lim;
   assign host_cfg_o.target_addr         = s_q.taddr;
   assign host_cfg_o.write_length_field  = s_q.wlen;
   assign host_cfg_o.read_length_field   = s_q.rlen;
   assign host_cfg_o.rd_ptr              = s_q.rd_ptr;
   assign host_cfg_o.wr_ptr              = s_q.wr_ptr;

   // ============================================================
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence ptr_clear_s;
      wr_i && addr_i == efh_pkg::HOST_STATUS_ADDR && wdata_i[efh_pkg::ST_PTR_CLR];
   endsequence
   sequence ptr_home_s;
      host_cfg_o.rd_ptr == 4'h0 && host_cfg_o.wr_ptr == 3'h1;
   endsequence
   sequence status_read_s;
      rd_i && addr_i == efh_pkg::HOST_STATUS_ADDR;
   endsequence

   ptr_clear_a: assert property (ptr_clear_s |=> ptr_home_s)
      else $error("pointers not at home after clear");

   status_bit7_a: assert property (status_read_s |=> !rdata_o[7])
      else $error("status bit 7 read back as one");

   // A same-cycle clear loses, so the flag always follows the event
   line_err_a: assert property (host_evt_i.line_fault
      |=> s_q.line_err)
      else $error("line error flag not set");

   done_set_wins_a: assert property (host_evt_i.stop_seen |=> s_q.done)
      else $error("stop event lost against clear");

   wfcs_mode_a: assert property (host_evt_i.alternate_sideband_mode && !s_q.wfcs
      |=> !s_q.wfcs)
      else $error("write check flag set in sideband mode");

   busy_read_a: assert property (host_evt_i.busy ##1 status_read_s
      |=> rdata_o[efh_pkg::ST_BUSY])
      else $error("busy not reported");

   hiz_track_a: assert property (s_q.hiz == $past(host_evt_i.line_hiz))
      else $error("high impedance status stale");

   taddr_store_a: assert property (wr_i && addr_i == efh_pkg::HOST_TADDR_ADDR
      |=> host_cfg_o.target_addr == $past(wdata_i))
      else $error("target address not stored");

   cnt_pair_a: assert property (rd_i && addr_i == efh_pkg::TACH_CNT_LO[0]
      ##1 (rd_i && addr_i == efh_pkg::TACH_CNT_HI[0])
      |=> rdata_o == $past(tach_count_i[0][15:8], 2))
      else $error("count high byte not from low read");

   slope_map_a: assert property (wr_i && addr_i == efh_pkg::FAN_CTRL_ADDR[0]
      |=> fan_cfg_o[0].slope[5:0] == $past(wdata_i[5:0]))
      else $error("slope low bits wrong");

   unmapped_a: assert property (rd_i && addr_i == 8'h90 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");

endmodule : efh_regs

`default_nettype wire
